// ---- logic/config_word_loader.sv ----
// reset-time loader of the two flash configuration words
// assumes a flash read port on clk that answers with a valid pulse,
// and a table access port driven on clk by the core or the programmer
`timescale 1ns/1ps

module config_word_loader
  import config_loader_pkg::*;
#(
  parameter logic [23:0] WORD1_ADDR = W1_ADDR_LARGE,
  parameter logic [23:0] WORD2_ADDR = W2_ADDR_LARGE
)(
  input  wire logic        clk,
  input  wire logic        rst,
  // flash read port
  output logic             flash_rd_req,
  output logic [23:0]      flash_rd_addr_q,
  input  wire logic [23:0] flash_rd_data,
  input  wire logic        flash_rd_valid,
  // table access port
  input  wire logic        tbl_req,
  input  wire logic        tbl_write,
  input  wire logic        tbl_from_serial,
  input  wire logic [23:0] tbl_addr,
  input  wire logic [23:0] tbl_wdata,
  output logic             tbl_ack_q,
  output logic             tbl_refused_q,
  output logic [23:0]      tbl_rdata_q,
  // flash programming request
  output logic             prog_wr_valid_q,
  output logic [23:0]      prog_wr_addr_q,
  output logic [23:0]      prog_wr_data_q,
  // settings to the subsystems
  output logic             core_hold_q,
  output logic             scan_port_enable,
  output logic             code_protect_on,
  output logic             write_protect_on,
  output logic             debug_entry,
  output logic             emulator_pin_select,
  output logic             watchdog_enable_fuse,
  output logic             windowed_watchdog,
  output logic [7:0]       prescale_ratio,
  output logic [15:0]      postscale_ratio
);

  // ****************************************************************
  // types and helpers
  // ****************************************************************
  typedef enum logic [1:0] {
    FETCH_W1,
    FETCH_W2,
    LOADED
  } load_state_e;

  // index of a location in configuration space, valid flag on top
  function automatic logic [3:0] loc_decode(input logic [23:0] addr);
    logic [23:0] off;
    off = addr - CFG_BASE;
    loc_decode = 4'h0;
    if (addr >= CFG_BASE && !off[0] && off[23:1] < 23'(LOC_COUNT)) begin
      loc_decode = {1'b1, off[3:1]};
    end
  endfunction : loc_decode

  function automatic logic [15:0] loc_word(input logic [2:0] idx,
                                           input logic [15:0] w1,
                                           input logic [15:0] w2);
    loc_word = LOC_FROM_W2[idx] ? w2 : w1;
  endfunction : loc_word

  // ****************************************************************
  // state
  // ****************************************************************
  load_state_e state_q;
  logic [15:0] word1_q;
  logic [15:0] word2_q;
  logic        fetch_done;
  logic [3:0]  loc_hit;
  logic [2:0]  loc_idx;
  logic [15:0] loc_src;
  logic [15:0] loc_mask;
  logic [15:0] rd_val;
  logic [15:0] wr_val;
  logic        in_cfg_space;
  logic        wr_allowed;

  logic        dec_scan;
  logic        dec_cp;
  logic        dec_wp;
  logic        dec_debug;
  logic        dec_pin;
  logic        dec_dog_en;
  logic        dec_window;
  logic [7:0]  dec_pre;
  logic [15:0] dec_post;

  // ****************************************************************
  // load sequencer
  // ****************************************************************
  assign fetch_done   = flash_rd_valid && state_q != LOADED;
  assign flash_rd_req = state_q != LOADED;

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= FETCH_W1;
    end else begin
      case (state_q)
        FETCH_W1: begin
          if (flash_rd_valid) begin
            state_q <= FETCH_W2;
          end
        end
        FETCH_W2: begin
          if (flash_rd_valid) begin
            state_q <= LOADED;
          end
        end
        LOADED: begin
          state_q <= LOADED;
        end
        default: begin
          state_q <= FETCH_W1;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      flash_rd_addr_q <= WORD1_ADDR;
    end else if (state_q == FETCH_W1 && flash_rd_valid) begin
      flash_rd_addr_q <= WORD2_ADDR;
    end
  end

  // volatile copies start unprogrammed so a partial load is harmless
  always_ff @(posedge clk) begin
    if (rst) begin
      word1_q <= WORD_UNPROG;
      word2_q <= WORD_UNPROG;
    end else if (fetch_done) begin
      // upper byte has no function and is dropped
      if (state_q == FETCH_W1) begin
        word1_q <= flash_rd_data[15:0];
      end else begin
        word2_q <= flash_rd_data[15:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      core_hold_q <= 1'b1;
    end else if (state_q == FETCH_W2 && flash_rd_valid) begin
      core_hold_q <= 1'b0;
    end
  end

  // ****************************************************************
  // decoded settings
  // ****************************************************************
  config_field_decoder u_decoder (
    .word1                (word1_q),
    .scan_port_enable     (dec_scan),
    .code_protect_on      (dec_cp),
    .write_protect_on     (dec_wp),
    .debug_entry          (dec_debug),
    .emulator_pin_select  (dec_pin),
    .watchdog_enable_fuse (dec_dog_en),
    .windowed_watchdog    (dec_window),
    .prescale_ratio       (dec_pre),
    .postscale_ratio      (dec_post)
  );

  // words only change during a load, so these hold between resets
  always_ff @(posedge clk) begin
    scan_port_enable     <= dec_scan;
    code_protect_on      <= dec_cp;
    write_protect_on     <= dec_wp;
    debug_entry          <= dec_debug;
    emulator_pin_select  <= dec_pin;
    watchdog_enable_fuse <= dec_dog_en;
    windowed_watchdog    <= dec_window;
    prescale_ratio       <= dec_pre;
    postscale_ratio      <= dec_post;
  end

  // ****************************************************************
  // table access to configuration space
  // ****************************************************************
  assign in_cfg_space = tbl_addr >= CFG_SPACE_LO;
  assign loc_hit      = loc_decode(tbl_addr);
  assign loc_idx      = loc_hit[2:0];
  assign loc_src      = loc_word(loc_idx, word1_q, word2_q);
  assign loc_mask     = LOC_MASK[loc_idx];
  // a protected flash refuses programming, and nothing during a load
  assign wr_allowed   = !core_hold_q && word1_q[BIT_WR_PROT];

  always_comb begin
    rd_val = loc_src | ~loc_mask;
    if (LOC_FROM_W2[loc_idx]) begin
      rd_val = rd_val | ~W2_IMPL;
    end else begin
      rd_val = (rd_val | W1_FORCE_ONE) & ~W1_FORCE_ZERO;
    end
  end

  always_comb begin
    wr_val = (loc_src & ~loc_mask) | (tbl_wdata[15:0] & loc_mask);
    // the scan enable is locked against the scan port itself
    if (!LOC_FROM_W2[loc_idx] && !tbl_from_serial) begin
      wr_val[BIT_SCAN] = word1_q[BIT_SCAN];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tbl_ack_q     <= 1'b0;
      tbl_refused_q <= 1'b0;
      tbl_rdata_q   <= {UPPER_ONES, WORD_UNPROG};
    end else begin
      tbl_ack_q     <= tbl_req && in_cfg_space;
      tbl_refused_q <= tbl_req && in_cfg_space && tbl_write
                       && !(wr_allowed && loc_hit[3]);
      if (tbl_req && in_cfg_space && !tbl_write) begin
        // unmapped locations read as unprogrammed
        tbl_rdata_q <= loc_hit[3] ? {UPPER_ONES, rd_val}
                                  : {UPPER_ONES, WORD_UNPROG};
      end
    end
  end

  // writes go to flash only; active settings wait for the next reset
  always_ff @(posedge clk) begin
    if (rst) begin
      prog_wr_valid_q <= 1'b0;
      prog_wr_addr_q  <= WORD1_ADDR;
      prog_wr_data_q  <= {UPPER_ONES, WORD_UNPROG};
    end else begin
      prog_wr_valid_q <= 1'b0;
      if (tbl_req && tbl_write && loc_hit[3] && wr_allowed) begin
        prog_wr_valid_q <= 1'b1;
        prog_wr_addr_q  <= LOC_FROM_W2[loc_idx] ? WORD2_ADDR : WORD1_ADDR;
        prog_wr_data_q  <= {UPPER_ONES, wr_val};
      end
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_w1_taken;
    state_q == FETCH_W1 && flash_rd_valid;
  endsequence

  sequence s_w2_taken;
    state_q == FETCH_W2 && flash_rd_valid;
  endsequence

  a_first_fetch_addr: assert property (
    $fell(rst) |-> flash_rd_req && flash_rd_addr_q == WORD1_ADDR
                   && core_hold_q && word1_q == WORD_UNPROG)
    else $error("load did not restart at word one");

  a_second_fetch_addr: assert property (
    s_w1_taken |=> flash_rd_req && flash_rd_addr_q == WORD2_ADDR
                   && word1_q == $past(flash_rd_data[15:0]))
    else $error("word one not captured or word two not requested");

  // any flash latency is legal, so only the closing fetch is pinned here
  a_hold_release: assert property (
    s_w2_taken |=> !core_hold_q && !flash_rd_req
                   && word2_q == $past(flash_rd_data[15:0]))
    else $error("core released without a complete load");

  a_hold_while_loading: assert property (
    flash_rd_req |-> core_hold_q)
    else $error("core running while load is pending");

  a_settings_stable: assert property (
    !core_hold_q && !$past(core_hold_q, 2)
      |-> $stable(scan_port_enable) && $stable(postscale_ratio)
          && $stable(watchdog_enable_fuse) && $stable(debug_entry))
    else $error("settings changed between resets");

  a_window_needs_en: assert property (
    windowed_watchdog |-> watchdog_enable_fuse)
    else $error("windowed watchdog without enable");

  a_postscale_map: assert property (
    !core_hold_q |=> postscale_ratio == (POSTSCALE_ONE << $past(word1_q[PS_MSB:0])))
    else $error("postscaler ratio does not follow its field");

  a_prescale_map: assert property (
    !core_hold_q |=> prescale_ratio
      == ($past(word1_q[BIT_PRESCALE]) ? PRESCALE_HI : PRESCALE_LO))
    else $error("prescaler ratio does not follow its field");

  a_protect_map: assert property (
    !core_hold_q |=> code_protect_on == !$past(word1_q[BIT_READ_PROT])
                     && write_protect_on == !$past(word1_q[BIT_WR_PROT]))
    else $error("protection outputs do not follow their fields");

  a_debug_entry_map: assert property (
    !core_hold_q |=> debug_entry == !$past(word1_q[BIT_DEBUG]))
    else $error("debug entry does not follow its field");

  a_pin_pair_map: assert property (
    !core_hold_q |=> emulator_pin_select == $past(word1_q[BIT_PIN_PAIR]))
    else $error("emulator pin pair does not follow its field");

  a_dog_enable_map: assert property (
    !core_hold_q |=> watchdog_enable_fuse == $past(word1_q[BIT_DOG_EN]))
    else $error("watchdog enable does not follow its field");

  a_scan_enable_map: assert property (
    !core_hold_q |=> scan_port_enable == $past(word1_q[BIT_SCAN]))
    else $error("scan port enable does not follow its field");

  a_unimpl_read_one: assert property (
    tbl_req && !tbl_write && loc_hit[3] && !LOC_FROM_W2[loc_idx]
      |=> tbl_ack_q && tbl_rdata_q[23:16] == UPPER_ONES
          && tbl_rdata_q[9] && tbl_rdata_q[5])
    else $error("unimplemented word one bits not read as one");

  a_reserved_read_zero: assert property (
    tbl_req && !tbl_write && loc_hit[3] && !LOC_FROM_W2[loc_idx]
      |=> !tbl_rdata_q[BIT_RSVD_ZERO])
    else $error("reserved word one bit not read as zero");

  a_scan_lock: assert property (
    tbl_req && tbl_write && !tbl_from_serial && loc_hit[3]
      && !LOC_FROM_W2[loc_idx] && wr_allowed
      |=> prog_wr_valid_q && prog_wr_data_q[BIT_SCAN] == word1_q[BIT_SCAN])
    else $error("scan enable changed from the scan port");

  // a write outside configuration space gets no answer at all, so no refusal
  a_write_protect: assert property (
    !word1_q[BIT_WR_PROT] && tbl_req && tbl_write
      |=> !prog_wr_valid_q && tbl_refused_q == $past(in_cfg_space))
    else $error("write passed while flash write protected");

  a_upper_byte_ones: assert property (
    prog_wr_valid_q |-> prog_wr_data_q[23:16] == UPPER_ONES)
    else $error("programmed word upper byte not all ones");

  a_outside_ignored: assert property (
    tbl_req && !in_cfg_space |=> !tbl_ack_q && !prog_wr_valid_q)
    else $error("table access answered outside configuration space");

endmodule : config_word_loader

// ---- logic/config_loader_pkg.sv ----
// constants for the reset-time configuration loader
// assumes one 100 MHz clock and a synchronous, active-high reset
//
// Operation
// - a programmed bit reads 0, an unprogrammed bit reads 1
// - configuration space starts at 800000h with its locations at F80000h, reached by table access only
// - active configuration registers are volatile and reloaded after power-up
// - words are fetched from the two highest program flash words
// - every reset copies both flash words into the configuration registers
// - packed words are unpacked into five configuration space locations
// - bit 14 enables the scan port, changeable only via serial programming
// - bit 13 low turns on code protection of all program memory
// - bit 12 low blocks all program memory writes
// - bit 11 low makes the device leave reset in debug mode
// - bit 8 high routes the emulator to pin pair two
// - bit 7 high enables the watchdog timer
// - bit 6 low selects windowed watchdog, which needs bit 7 high
// - bit 4 sets watchdog prescaler, 1:128 when high, 1:32 when low
// - bits 3 to 0 set watchdog postscaler 1:2^n
// - bit 15 is written 0, bit 10 written 1; bit 15 reads 0
// - bits 23 to 16, 9 and 5 of word one read as 1

package config_loader_pkg;

  // ****************************************************************
  // address map
  // ****************************************************************
  localparam logic [23:0] CFG_SPACE_LO  = 24'h80_0000;
  localparam logic [23:0] CFG_BASE      = 24'hF8_0000;
  localparam int          LOC_COUNT     = 5;
  localparam logic [23:0] LOC_STRIDE    = 24'h00_0002;

  localparam logic [23:0] W1_ADDR_LARGE = 24'h01_57FE;
  localparam logic [23:0] W2_ADDR_LARGE = 24'h01_57FC;
  localparam logic [23:0] W1_ADDR_MID   = 24'h00_FFFE;
  localparam logic [23:0] W2_ADDR_MID   = 24'h00_FFFC;
  localparam logic [23:0] W1_ADDR_SMALL = 24'h00_ABFE;
  localparam logic [23:0] W2_ADDR_SMALL = 24'h00_ABFC;

  // ****************************************************************
  // word one field positions
  // ****************************************************************
  localparam int BIT_RSVD_ZERO = 15;
  localparam int BIT_SCAN      = 14;
  localparam int BIT_READ_PROT = 13;
  localparam int BIT_WR_PROT   = 12;
  localparam int BIT_DEBUG     = 11;
  localparam int BIT_PIN_PAIR  = 8;
  localparam int BIT_DOG_EN    = 7;
  localparam int BIT_WIN_DIS   = 6;
  localparam int BIT_PRESCALE  = 4;
  localparam int PS_MSB        = 3;

  // ****************************************************************
  // reset values and read-back shaping
  // ****************************************************************
  localparam logic [15:0] WORD_UNPROG   = 16'hFFFF;
  localparam logic [7:0]  UPPER_ONES    = 8'hFF;
  localparam logic [15:0] W1_FORCE_ONE  = 16'h0220;
  localparam logic [15:0] W1_FORCE_ZERO = 16'h8000;
  localparam logic [15:0] W2_IMPL       = 16'h87E3;
  localparam logic [7:0]  PRESCALE_HI   = 8'h80;
  localparam logic [7:0]  PRESCALE_LO   = 8'h20;
  localparam logic [15:0] POSTSCALE_ONE = 16'h0001;

  // five destination locations: field mask and source word
  localparam logic [15:0] LOC_MASK [LOC_COUNT] = '{
    16'hF000, 16'h0F00, 16'h00FF, 16'hFF00, 16'h00FF
  };
  localparam logic [LOC_COUNT-1:0] LOC_FROM_W2 = 5'h18;

endpackage : config_loader_pkg

// ---- logic/config_field_decoder.sv ----
// decodes configuration word one into subsystem settings
// assumes the word is held in flip-flops by the caller
`timescale 1ns/1ps

module config_field_decoder
  import config_loader_pkg::*;
(
  input  wire logic [15:0] word1,
  output logic             scan_port_enable,
  output logic             code_protect_on,
  output logic             write_protect_on,
  output logic             debug_entry,
  output logic             emulator_pin_select,
  output logic             watchdog_enable_fuse,
  output logic             windowed_watchdog,
  output logic [7:0]       prescale_ratio,
  output logic [15:0]      postscale_ratio
);

  always_comb begin
    scan_port_enable     = word1[BIT_SCAN];
    code_protect_on      = ~word1[BIT_READ_PROT];
    write_protect_on     = ~word1[BIT_WR_PROT];
    debug_entry          = ~word1[BIT_DEBUG];
    emulator_pin_select  = word1[BIT_PIN_PAIR];
    watchdog_enable_fuse = word1[BIT_DOG_EN];
    // a window without a running watchdog is meaningless
    windowed_watchdog    = word1[BIT_DOG_EN] & ~word1[BIT_WIN_DIS];
    prescale_ratio       = word1[BIT_PRESCALE] ? PRESCALE_HI : PRESCALE_LO;
    postscale_ratio      = POSTSCALE_ONE << word1[PS_MSB:0];
  end

endmodule : config_field_decoder

// ---- tb/flash_word_model.sv ----
// behavioural program flash that holds the two configuration words
// assumes the loader's read port on the same clock; answers after a set delay
`timescale 1ns/1ps

module flash_word_model
  import config_loader_pkg::*;
#(
  parameter logic [23:0] WORD1_ADDR = W1_ADDR_LARGE,
  parameter logic [23:0] WORD2_ADDR = W2_ADDR_LARGE
)(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        rd_req,
  input  wire logic [23:0] rd_addr,
  input  wire logic [23:0] word1,
  input  wire logic [23:0] word2,
  input  wire logic [3:0]  latency,
  output logic             rd_valid,
  output logic [23:0]      rd_data
);
  logic [3:0] wait_q;

  // ****************************************************************
  // read timing and data bus
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (rst || !rd_req || rd_valid) begin
      wait_q   <= 4'h0;
      rd_valid <= 1'b0;
    end else if (wait_q == latency) begin
      rd_valid <= 1'b1;
    end else begin
      wait_q <= wait_q + 4'h1;
    end
  end

  // outside a valid cycle the bus toggles, so a sample one cycle late reads the inverted word
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_data <= 24'h5A_5A5A;
    end else if (rd_req && !rd_valid && wait_q == latency) begin
      // only the configuration words live at these addresses
      rd_data <= (rd_addr == WORD1_ADDR) ? word1 :
                 (rd_addr == WORD2_ADDR) ? word2 : 24'hFF_FFFF;
    end else begin
      rd_data <= ~rd_data;
    end
  end
endmodule : flash_word_model

// ---- tb/config_word_loader_tb_top.sv ----
// self-checking bench for the configuration word loader
// assumes the loader and a behavioural flash model on one 100 MHz clock
`timescale 1ns/1ps

module config_word_loader_tb_top
  import config_loader_pkg::*;
;
  // upper byte all ones, bit 15 written 0; bit 10 written 1 in W_A and W_C
  localparam logic [23:0] W_A = 24'hFF_7C95;
  localparam logic [23:0] W_B = 24'hFF_0000;
  localparam logic [23:0] W_C = 24'hFF_6C95;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        tbl_req = 1'b0;
  logic        tbl_write = 1'b0;
  logic        tbl_from_serial = 1'b0;
  logic [23:0] tbl_addr = 24'h00_0000;
  logic [23:0] tbl_wdata = 24'h00_0000;
  logic [23:0] word1 = 24'hFF_FFFF;
  logic [23:0] word2 = 24'hFF_FFFF;
  logic [3:0]  flash_lat = 4'h0;
  logic        flash_rd_req, flash_rd_valid, tbl_ack_q, tbl_refused_q;
  logic        prog_wr_valid_q, core_hold_q, scan_port_enable, code_protect_on;
  logic        write_protect_on, debug_entry, emulator_pin_select;
  logic        watchdog_enable_fuse, windowed_watchdog;
  logic [7:0]  prescale_ratio;
  logic [15:0] postscale_ratio;
  logic [23:0] flash_rd_addr_q, flash_rd_data, tbl_rdata_q, prog_wr_addr_q, prog_wr_data_q;
  logic [23:0] addr_seen [2];
  logic [23:0] w;
  // reserved bit 15 of word one reads back as 0 in every word one location
  logic [23:0] rd_exp [6] = '{24'hFF_7FFF, 24'hFF_7EFF, 24'hFF_7FB5, 24'hFF_78FF,
                              24'hFF_FF1C, 24'hFF_FFFF};
  int          fetch_count = 0;
  int          mismatches = 0;
  int          comparisons = 0;

  always #5 clk = ~clk;

  config_word_loader dut_u (
    .clk(clk), .rst(rst), .flash_rd_req(flash_rd_req), .flash_rd_addr_q(flash_rd_addr_q),
    .flash_rd_data(flash_rd_data), .flash_rd_valid(flash_rd_valid), .tbl_req(tbl_req),
    .tbl_write(tbl_write), .tbl_from_serial(tbl_from_serial), .tbl_addr(tbl_addr),
    .tbl_wdata(tbl_wdata), .tbl_ack_q(tbl_ack_q), .tbl_refused_q(tbl_refused_q),
    .tbl_rdata_q(tbl_rdata_q), .prog_wr_valid_q(prog_wr_valid_q),
    .prog_wr_addr_q(prog_wr_addr_q), .prog_wr_data_q(prog_wr_data_q),
    .core_hold_q(core_hold_q), .scan_port_enable(scan_port_enable),
    .code_protect_on(code_protect_on), .write_protect_on(write_protect_on),
    .debug_entry(debug_entry), .emulator_pin_select(emulator_pin_select),
    .watchdog_enable_fuse(watchdog_enable_fuse), .windowed_watchdog(windowed_watchdog),
    .prescale_ratio(prescale_ratio), .postscale_ratio(postscale_ratio)
  );

  flash_word_model flash_u (
    .clk(clk), .rst(rst), .rd_req(flash_rd_req), .rd_addr(flash_rd_addr_q),
    .word1(word1), .word2(word2), .latency(flash_lat),
    .rd_valid(flash_rd_valid), .rd_data(flash_rd_data)
  );

  // records which address each accepted fetch used
  always @(posedge clk) begin
    if (!rst && flash_rd_req && flash_rd_valid) begin
      if (fetch_count < 2) addr_seen[fetch_count] = flash_rd_addr_q;
      fetch_count = fetch_count + 1;
    end
  end

  // ****************************************************************
  // compare and report
  // ****************************************************************
  task automatic check_bit(input string name, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %b seen %b", name, exp, got);
    end
  endtask : check_bit

  task automatic check_word(input string name, input logic [23:0] exp, input logic [23:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : check_word

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  // ****************************************************************
  // access tasks
  // ****************************************************************
  task automatic check_settings(input logic [23:0] v);
    check_bit("scan", v[14], scan_port_enable);
    check_bit("code_prot", ~v[13], code_protect_on);
    check_bit("write_prot", ~v[12], write_protect_on);
    check_bit("debug", ~v[11], debug_entry);
    check_bit("pin_pair", v[8], emulator_pin_select);
    check_bit("dog_en", v[7], watchdog_enable_fuse);
    check_bit("windowed", v[7] & ~v[6], windowed_watchdog);
    check_word("prescale", v[4] ? 24'h80 : 24'h20, {16'h0000, prescale_ratio});
    check_word("postscale", 24'h00_0001 << v[3:0], {8'h00, postscale_ratio});
  endtask : check_settings

  task automatic start_load(input logic [23:0] a, input logic [23:0] b, input logic [3:0] lat,
                            input int hold);
    @(negedge clk);
    word1 = a;
    word2 = b;
    flash_lat = lat;
    rst = 1'b1;
    repeat (hold) @(negedge clk);
    rst = 1'b0;
    fetch_count = 0;
  endtask : start_load

  task automatic finish_load(input logic [23:0] a);
    int n;
    n = 0;
    while (core_hold_q !== 1'b0 && n < 60) begin
      @(negedge clk);
      n++;
    end
    check_word("fetches", 24'h00_0002, fetch_count[23:0]);
    check_word("w1_addr", W1_ADDR_LARGE, addr_seen[0]);
    check_word("w2_addr", W2_ADDR_LARGE, addr_seen[1]);
    @(negedge clk);
    check_settings(a);
  endtask : finish_load

  // one-cycle request; the answer is looked at in the cycle after it is taken
  task automatic tbl_check(input logic wr, input logic ser, input logic [23:0] a,
                           input logic [23:0] d, input logic ack, input logic refused,
                           input logic [23:0] exp);
    @(negedge clk);
    tbl_req = 1'b1;
    tbl_write = wr;
    tbl_from_serial = ser;
    tbl_addr = a;
    tbl_wdata = d;
    @(negedge clk);
    tbl_req = 1'b0;
    check_bit("ack", ack, tbl_ack_q);
    if (wr) begin
      check_bit("refused", refused, tbl_refused_q);
      check_bit("prog_valid", ~refused, prog_wr_valid_q);
      if (!refused) check_word("prog_data", exp, prog_wr_data_q);
      if (!refused) check_word("prog_addr", (a >= 24'hF8_0006) ? W2_ADDR_LARGE
                                             : W1_ADDR_LARGE, prog_wr_addr_q);
    end else if (ack) begin
      check_word("rdata", exp, tbl_rdata_q);
    end
  endtask : tbl_check

  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    #100000;
    mismatches++;
    final_report();
  end

  initial begin
    start_load(W_A, W_B, 4'h6, 12);
    tbl_check(1'b1, 1'b1, CFG_BASE, 24'h00_0000, 1'b1, 1'b1, 24'h00_0000);
    finish_load(W_A);
    for (int i = 0; i < 6; i++) begin
      tbl_check(1'b0, 1'b0, CFG_BASE + 24'(2 * i), 24'h0, 1'b1, 1'b0, rd_exp[i]);
    end
    tbl_check(1'b0, 1'b0, 24'h7F_FFFE, 24'h00_0000, 1'b0, 1'b0, 24'h00_0000);
    tbl_check(1'b1, 1'b1, CFG_BASE, 24'h00_0000, 1'b1, 1'b0, 24'hFF_0C95);
    tbl_check(1'b1, 1'b0, CFG_BASE, 24'h00_0000, 1'b1, 1'b0, 24'hFF_4C95);
    tbl_check(1'b1, 1'b1, 24'hF8_0006, 24'h00_1234, 1'b1, 1'b0, 24'hFF_1200);
    tbl_check(1'b1, 1'b1, 24'hF8_000C, 24'h00_0000, 1'b1, 1'b1, 24'h00_0000);
    check_settings(W_A);
    for (int n = 0; n < 16; n++) begin
      w = {8'hFF, 1'b0, n[0], n[1], n[2], n[3], 2'b11, n[1], n[3], n[0], 1'b1, n[2], n[3:0]};
      start_load(w, 24'hFF_5A5A, n[3:0], 2);
      finish_load(w);
    end
    start_load(W_C, W_B, 4'h0, 2);
    finish_load(W_C);
    tbl_check(1'b1, 1'b1, CFG_BASE, 24'h00_0000, 1'b1, 1'b1, 24'h00_0000);
    final_report();
  end
endmodule : config_word_loader_tb_top
